// [core/rptlp_pkg.sv]
package rptlp_pkg;
  // ****************************************************
  // Register map of the device's register port
  // ****************************************************
  localparam logic [13:0] TX_LOW_OFS      = 14'h2000;
  localparam logic [13:0] TX_HIGH_OFS     = 14'h2004;
  localparam logic [13:0] TX_CTRL_OFS     = 14'h2008;
  localparam logic [13:0] CPL_STATUS_OFS  = 14'h2010;
  localparam logic [13:0] CPL_LOW_OFS     = 14'h2014;
  localparam logic [13:0] CPL_HIGH_OFS    = 14'h2018;
  localparam logic [13:0] IRQ_STATUS_OFS  = 14'h3060;
  localparam int          TX_SOP_BIT      = 1;
  localparam int          TX_EOP_BIT      = 0;
  localparam int          CPL_SOP_BIT     = 1;
  localparam int          CPL_EOP_BIT     = 0;
  localparam int          CPL_CNT_LSB     = 8;
  localparam int          CPL_CNT_MSB     = 15;
  localparam int          IRQ_CPL_BIT     = 4;
  localparam logic [31:0] RESET_WORD      = 32'h0000_0000;
  // ****************************************************
  // Controller register map (software side)
  // ****************************************************
  localparam logic [7:0]  C_TX_LOW_OFS    = 8'h00;
  localparam logic [7:0]  C_TX_HIGH_OFS   = 8'h04;
  localparam logic [7:0]  C_CMD_OFS       = 8'h08;
  localparam logic [7:0]  C_STATUS_OFS    = 8'h0c;
  localparam logic [7:0]  C_RX_LOW_OFS    = 8'h10;
  localparam logic [7:0]  C_RX_HIGH_OFS   = 8'h14;
  localparam logic [7:0]  C_RX_FLAGS_OFS  = 8'h18;
  localparam int          CMD_SEND_BIT    = 0;
  localparam int          CMD_SOP_BIT     = 1;
  localparam int          CMD_EOP_BIT     = 2;
  localparam int          CMD_POLL_BIT    = 3;
  localparam logic [31:0] UNMAPPED_WORD   = 32'h0000_0000;
endpackage : rptlp_pkg

// [core/rptlp_if.sv]
`timescale 1ns/1ps
interface rptlp_if;
  logic [13:0] address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        irq;
  modport device (input address, input read, input write, input writedata,
                  output readdata, output waitrequest, output irq);
  modport host   (output address, output read, output write, output writedata,
                  input readdata, input waitrequest, input irq);
endinterface : rptlp_if

// [core/rptlp_fifo.sv]
`timescale 1ns/1ps
module rptlp_fifo #(
  parameter int W = 66,
  parameter int D = 16
) (
  input  wire logic         clk_sys,  // System clock
  input  wire logic         resetn,   // Sync reset, low
  input  wire logic         in_valid, // Push
  output logic              in_ready, // Not full
  input  wire logic [W-1:0] in_data,  // Entry in
  output logic              out_valid,// Not empty
  input  wire logic         out_ready,// Pop
  output logic [W-1:0]      out_data, // Head entry
  output logic [7:0]        count     // Entries held
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   n;
  } rptlp_fifo_t;
  rptlp_fifo_t s_q, s_d;
  logic [W-1:0] mem [D];
  logic push, pop;

  assign in_ready  = s_q.n != (AW+1)'(D);
  assign out_valid = s_q.n != '0;
  assign out_data  = mem[s_q.rp];
  assign count     = 8'(s_q.n);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) s_d.wp = s_q.wp + 1'b1;
    if (pop) s_d.rp = s_q.rp + 1'b1;
    s_d.n = s_q.n + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) s_q <= '0;
    else s_q <= s_d;
    if (push) mem[s_q.wp] <= in_data;
  end
endmodule : rptlp_fifo

// [core/rptlp_port.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Transmit low/high dword registers at 0x2000/4.
// - Control bit1 start, bit0 end.
// - Status [15:8] completion FIFO count (registered, plus one unless empty or full); bits 1:0 clear-on-read.
// - Status bit1 set at first completion data.
// - Status bit0 set at final completion data.
// - Completion dwords read at 0x2014/0x2018.
// - Accepts config, message, I/O, single-dword memory.
// - Assembled packets go out on direct channel.
// - Software formats headers, aligns payload.
// - Software writes both dwords every qword.
// - No type 0 device-number filtering.
// - Same writes for 64 or 128 datapath.
// - One non-posted request outstanding.
// - Software uses tags 16 to 31.
// - Start-flag write pushes first two dwords.
// - Further qwords: control write, end or not.
// - Register packets beat slave-port packets.
// - Completions buffered, moved qword by qword.
// - Software polls start, reads, checks end.
// - Completion sets sticky bit 4 at 0x3060.
module rptlp_port #(
  parameter int DEPTH = 16
) (
  input  wire logic        clk_sys,       // System clock
  input  wire logic        resetn,        // Sync reset, low
  rptlp_if.device          bus,           // Register port
  output logic [65:0]      tx_data,       // {sop,eop,high,low} qword
  output logic             tx_valid,      // Direct channel qword valid
  input  wire logic        tx_ready,      // Direct channel ready
  output logic             tx_reg_prio,   // Register packet owns channel
  input  wire logic [65:0] cpl_data,      // {sop,eop,high,low} completion qword
  input  wire logic        cpl_valid,     // Completion qword valid
  output logic             cpl_ready      // Completion FIFO ready
);
  // ****************************************************
  // State, one packed record registered as a whole
  // ****************************************************
  typedef struct packed {
    logic [31:0] tx_lo;
    logic [31:0] tx_hi;
    logic [1:0]  ctrl;
    logic [65:0] cur;
    logic        cur_v;
    logic        sop_f;
    logic        eop_f;
    logic [7:0]  cnt;
    logic        irq_f;
    logic        in_pkt;
    logic        wait_q;
    logic [31:0] rdata;
    logic [65:0] txo;
    logic        txv;
    logic        prio;
  } rptlp_port_t;
  rptlp_port_t s_q, s_d;
  logic        ff_ready, ff_valid, ff_pop;
  logic [65:0] ff_data;
  logic [7:0]  ff_cnt;
  logic        acc, wr, rd;

  // ****************************************************
  // Helpers
  // ****************************************************
  // Completion status word: registered count (FIFO count plus one unless empty or full), then start and end markers
  function automatic logic [31:0] status_word(input logic [7:0] n,
                                              input logic       s,
                                              input logic       e);
    status_word = {16'h0, n, 6'h0, s, e};
  endfunction : status_word

  // One qword for the direct channel; the same layout at any datapath width
  function automatic logic [65:0] tx_qword(input logic [31:0] w,
                                           input logic [31:0] hi,
                                           input logic [31:0] lo);
    tx_qword = {w[rptlp_pkg::TX_SOP_BIT], w[rptlp_pkg::TX_EOP_BIT], hi, lo};
  endfunction : tx_qword

  // Read of the completion high dword, which retires the shown qword
  function automatic logic is_cpl_high(input logic r, input logic [13:0] a);
    is_cpl_high = r && (a == rptlp_pkg::CPL_HIGH_OFS);
  endfunction : is_cpl_high

  // Packet-open flag after a control write: start opens, end closes
  function automatic logic next_open(input logic cur, input logic [31:0] w);
    next_open = cur;
    if (w[rptlp_pkg::TX_SOP_BIT]) next_open = 1'b1;
    if (w[rptlp_pkg::TX_EOP_BIT]) next_open = 1'b0;
  endfunction : next_open

  // ****************************************************
  // Completion FIFO
  // ****************************************************
  rptlp_fifo #(.W(66), .D(DEPTH)) u_cpl (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .in_valid (cpl_valid),
    .in_ready (ff_ready),
    .in_data  (cpl_data),
    .out_valid(ff_valid),
    .out_ready(ff_pop),
    .out_data (ff_data),
    .count    (ff_cnt)
  );

  // ****************************************************
  // Bus slave: one wait state, answer on the next edge
  // ****************************************************
  assign acc = (bus.read || bus.write) && s_q.wait_q;
  assign wr  = acc && bus.write;
  // Reads decode in the wait state, so their word already stands at the edge
  // where waitrequest is low; the held request cannot decode a second time,
  // which keeps clear-on-read and pops to one per access
  assign rd  = bus.read && !s_q.wait_q;
  // Load the display when empty or once the final qword's high dword is read
  assign ff_pop = ff_valid && (!s_q.cur_v ||
                  (is_cpl_high(rd, bus.address) && s_q.cur[64]));

  always_comb begin
    s_d = s_q;
    s_d.wait_q = (bus.read || bus.write) && !s_q.wait_q;
    if (s_q.txv && tx_ready) s_d.txv = 1'b0;
    if (ff_valid && ff_ready) s_d.cnt = ff_cnt + 8'h1;
    else s_d.cnt = ff_cnt;
    // ****************************************************
    // Writes land at the edge where waitrequest is low
    // ****************************************************
    if (wr) begin
      unique case (bus.address)
        rptlp_pkg::TX_LOW_OFS:  s_d.tx_lo = bus.writedata;
        rptlp_pkg::TX_HIGH_OFS: s_d.tx_hi = bus.writedata;
        rptlp_pkg::TX_CTRL_OFS: begin
          s_d.ctrl = bus.writedata[1:0];
          // Every control write pushes one qword; width-independent format
          s_d.txo = tx_qword(bus.writedata, s_q.tx_hi, s_q.tx_lo);
          s_d.txv = 1'b1;
          s_d.in_pkt = next_open(s_q.in_pkt, bus.writedata);
        end
        rptlp_pkg::IRQ_STATUS_OFS:
          if (bus.writedata[rptlp_pkg::IRQ_CPL_BIT]) s_d.irq_f = 1'b0;
        default: ;
      endcase
    end
    // ****************************************************
    // Reads: decoded once, in the wait state
    // ****************************************************
    // Status read clears both markers; a load in this cycle still wins below
    if (rd) begin
      unique case (bus.address)
        rptlp_pkg::TX_LOW_OFS:  s_d.rdata = s_q.tx_lo;
        rptlp_pkg::TX_HIGH_OFS: s_d.rdata = s_q.tx_hi;
        rptlp_pkg::TX_CTRL_OFS: s_d.rdata = {30'h0, s_q.ctrl};
        rptlp_pkg::CPL_STATUS_OFS: begin
          s_d.rdata = status_word(s_q.cnt, s_q.sop_f, s_q.eop_f);
          s_d.sop_f = 1'b0;
          s_d.eop_f = 1'b0;
        end
        rptlp_pkg::CPL_LOW_OFS:  s_d.rdata = s_q.cur[31:0];
        rptlp_pkg::CPL_HIGH_OFS: begin
          s_d.rdata = s_q.cur[63:32];
          s_d.cur_v = 1'b0;
        end
        rptlp_pkg::IRQ_STATUS_OFS: s_d.rdata = {27'h0, s_q.irq_f, 4'h0};
        default: s_d.rdata = rptlp_pkg::UNMAPPED_WORD;
      endcase
    end
    // ****************************************************
    // Completion display
    // ****************************************************
    // Hardware set wins over a read clear in the same cycle
    if (ff_pop) begin
      s_d.cur   = ff_data;
      s_d.cur_v = 1'b1;
      if (ff_data[65]) begin
        s_d.sop_f = 1'b1;
        s_d.irq_f = 1'b1;
      end
      if (ff_data[64]) s_d.eop_f = 1'b1;
    end else if (!s_d.cur_v) begin
      s_d.sop_f = 1'b0;
      s_d.eop_f = 1'b0;
    end
    // Registered so the priority output comes straight from a flop
    s_d.prio = s_d.in_pkt || s_d.txv;
  end

  // ****************************************************
  // Registers and outputs
  // ****************************************************
  // Limitation: a control write while the last qword still waits replaces it;
  // the software path spaces its control writes far apart
  always_ff @(posedge clk_sys) begin
    if (!resetn) s_q <= '0;
    else s_q <= s_d;
  end

  // Read data is a register and stands until the next read decodes
  assign bus.readdata    = s_q.rdata;
  assign bus.waitrequest = !s_q.wait_q;
  assign bus.irq         = s_q.irq_f;
  assign tx_data         = s_q.txo;
  assign tx_valid        = s_q.txv;
  // Slave-port traffic must wait while a register packet is open
  assign tx_reg_prio     = s_q.prio;
  // Back-pressure completions once the FIFO is full
  assign cpl_ready       = ff_ready;
endmodule : rptlp_port

// [core/rptlp_ctrl.sv]
`timescale 1ns/1ps
module rptlp_ctrl (
  input  wire logic        clk_sys,       // System clock
  input  wire logic        resetn,        // Sync reset, low
  rptlp_if.host            port,          // Device register port
  input  wire logic [7:0]  s_address,     // Software address
  input  wire logic        s_read,        // Software read
  input  wire logic        s_write,       // Software write
  input  wire logic [31:0] s_writedata,   // Software write data
  output logic [31:0]      s_readdata,    // Software read data
  output logic             s_waitrequest  // Software wait
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001, ST_LO = 6'b000010, ST_HI = 6'b000100,
    ST_CTL  = 6'b001000, ST_POLL = 6'b010000, ST_RD = 6'b100000
  } rptlp_st_t;
  typedef struct packed {
    rptlp_st_t   st;
    logic [31:0] lo, hi, rx_lo, rx_hi;
    logic [1:0]  flags, rdidx, cmd;
    logic [13:0] a;
    logic        r, w;
    logic [31:0] wd, rdata;
    logic        ack;
  } rptlp_ctrl_t;
  rptlp_ctrl_t s_q, s_d;
  logic busy, done;

  assign busy = s_q.st != ST_IDLE;
  assign done = (s_q.r || s_q.w) && !port.waitrequest;

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    if ((s_read || s_write) && !s_q.ack) s_d.ack = 1'b1;
    // Writes land at the edge where the master sees waitrequest low
    if (s_write && s_q.ack) begin
      unique case (s_address)
        rptlp_pkg::C_TX_LOW_OFS:  s_d.lo = s_writedata;
        rptlp_pkg::C_TX_HIGH_OFS: s_d.hi = s_writedata;
        rptlp_pkg::C_CMD_OFS: if (!busy) begin
          s_d.cmd = {s_writedata[rptlp_pkg::CMD_SOP_BIT], s_writedata[rptlp_pkg::CMD_EOP_BIT]};
          if (s_writedata[rptlp_pkg::CMD_SEND_BIT]) s_d.st = ST_LO;
          else if (s_writedata[rptlp_pkg::CMD_POLL_BIT]) s_d.st = ST_POLL;
        end
        default: ;
      endcase
    end
    // Read data loads in the wait cycle so it stands when waitrequest drops
    if (s_read && !s_q.ack) begin
      unique case (s_address)
        rptlp_pkg::C_STATUS_OFS:   s_d.rdata = {31'h0, busy};
        rptlp_pkg::C_RX_LOW_OFS:   s_d.rdata = s_q.rx_lo;
        rptlp_pkg::C_RX_HIGH_OFS:  s_d.rdata = s_q.rx_hi;
        rptlp_pkg::C_RX_FLAGS_OFS: s_d.rdata = {30'h0, s_q.flags};
        default: s_d.rdata = rptlp_pkg::UNMAPPED_WORD;
      endcase
    end
    if (done) begin
      s_d.r = 1'b0;
      s_d.w = 1'b0;
    end
    unique case (s_q.st)
      ST_IDLE: ;
      ST_LO: if (!s_q.w || done) begin
        if (done) s_d.st = ST_HI;
        else begin
          s_d.a = rptlp_pkg::TX_LOW_OFS;
          s_d.wd = s_q.lo;
          s_d.w = 1'b1;
        end
      end
      ST_HI: if (!s_q.w || done) begin
        if (done) s_d.st = ST_CTL;
        else begin
          s_d.a = rptlp_pkg::TX_HIGH_OFS;
          s_d.wd = s_q.hi;
          s_d.w = 1'b1;
        end
      end
      ST_CTL: if (!s_q.w || done) begin
        if (done) s_d.st = ST_IDLE;
        else begin
          s_d.a = rptlp_pkg::TX_CTRL_OFS;
          s_d.wd = {30'h0, s_q.cmd};
          s_d.w = 1'b1;
        end
      end
      ST_POLL: if (!s_q.r || done) begin
        if (done) begin
          s_d.flags = port.readdata[1:0] | s_q.flags;
          if (port.readdata[rptlp_pkg::CPL_SOP_BIT] || s_q.flags != 2'h0) begin
            s_d.st = ST_RD;
            s_d.rdidx = 2'h0;
          end
        end else begin
          s_d.a = rptlp_pkg::CPL_STATUS_OFS;
          s_d.r = 1'b1;
        end
      end
      ST_RD: if (!s_q.r || done) begin
        if (done) begin
          if (s_q.rdidx == 2'h0) s_d.rx_lo = port.readdata;
          else s_d.rx_hi = port.readdata;
          s_d.rdidx = s_q.rdidx + 2'h1;
          if (s_q.rdidx == 2'h1) s_d.st = ST_IDLE;
        end else begin
          s_d.a = (s_q.rdidx == 2'h0) ? rptlp_pkg::CPL_LOW_OFS : rptlp_pkg::CPL_HIGH_OFS;
          s_d.r = 1'b1;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    if (s_q.st == ST_IDLE && s_d.st == ST_POLL) s_d.flags = 2'h0;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_q    <= '0;
      s_q.st <= ST_IDLE;
    end else s_q <= s_d;
  end

  assign port.address   = s_q.a;
  assign port.read      = s_q.r;
  assign port.write     = s_q.w;
  assign port.writedata = s_q.wd;
  assign s_readdata     = s_q.rdata;
  assign s_waitrequest  = !s_q.ack;
endmodule : rptlp_ctrl

// [tb/rptlp_properties.sv]
`timescale 1ns/1ps
module rptlp_properties (
  input wire logic        clk_sys,     // System clock
  input wire logic        resetn,      // Sync reset, low
  input wire logic [13:0] address,     // Device byte address
  input wire logic        read,        // Read request
  input wire logic        write,       // Write request
  input wire logic [31:0] writedata,   // Write data
  input wire logic [31:0] readdata,    // Read data
  input wire logic        waitrequest, // Wait, high
  input wire logic        irq          // Completion sticky
);
  logic [13:0] last_wr_q;
  logic        acc_wr;
  assign acc_wr = write && !waitrequest;
  // Reset value lets the first packet begin with a low dword
  always_ff @(posedge clk_sys) begin
    if (!resetn) last_wr_q <= rptlp_pkg::TX_CTRL_OFS;
    else if (acc_wr) last_wr_q <= address;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  AST_ONE_DIR: assert property (!(read && write))
    else $error("read and write together");
  AST_ACK_NEXT: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer one cycle after request");
  AST_ACK_PULSE: assert property (!waitrequest |=> waitrequest)
    else $error("answer longer than one cycle");
  AST_ACK_CAUSE: assert property (!waitrequest |-> (read || write) && $past(read || write))
    else $error("answer without request");
  AST_REQ_HOLD: assert property ((read || write) && waitrequest |=>
    $stable(address) && $stable(read) && $stable(write) && $stable(writedata))
    else $error("request changed while waiting");
  AST_HI_AFTER_LO: assert property (acc_wr && address == rptlp_pkg::TX_HIGH_OFS |->
    last_wr_q == rptlp_pkg::TX_LOW_OFS) else $error("high dword without low");
  AST_CTRL_AFTER_HI: assert property (acc_wr && address == rptlp_pkg::TX_CTRL_OFS |->
    last_wr_q == rptlp_pkg::TX_HIGH_OFS) else $error("control write without high");
  AST_CTRL_BITS: assert property (acc_wr && address == rptlp_pkg::TX_CTRL_OFS |->
    writedata[31:2] == 30'h0) else $error("control write sets reserved bits");
  AST_RDATA_HOLD: assert property (!read |=> $stable(readdata))
    else $error("read data changed without read");
  AST_IRQ_STICKY: assert property (irq && !(acc_wr && address == rptlp_pkg::IRQ_STATUS_OFS
    && writedata[4]) |=> irq) else $error("sticky bit lost");
endmodule : rptlp_properties

// [tb/tb_rptlp.sv]
`timescale 1ns/1ps
module tb_rptlp;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  s_address = 8'h00;
  logic        s_read = 1'b0;
  logic        s_write = 1'b0;
  logic [31:0] s_writedata = 32'h0;
  logic [31:0] s_readdata;
  logic        s_waitrequest;
  logic [65:0] tx_data;
  logic        tx_valid;
  logic        tx_ready = 1'b0;
  logic        tx_reg_prio;
  logic [65:0] cpl_data = 66'h0;
  logic        cpl_valid = 1'b0;
  logic        cpl_ready;
  logic [31:0] rd;
  logic [65:0] exp_tx[$];
  logic [65:0] exp_rx[$];
  logic        pkt_open = 1'b0;
  logic [7:0]  kinds [5] = '{8'h04, 8'h44, 8'h30, 8'h02, 8'h40};
  integer      seed = 32'h15b2;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  rptlp_if i_rptlp_if ();
  rptlp_port #(.DEPTH(16)) i_rptlp_port (.clk_sys(clk_sys), .resetn(resetn),
    .bus(i_rptlp_if), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_reg_prio(tx_reg_prio), .cpl_data(cpl_data), .cpl_valid(cpl_valid),
    .cpl_ready(cpl_ready));
  rptlp_ctrl i_rptlp_ctrl (.clk_sys(clk_sys), .resetn(resetn), .port(i_rptlp_if),
    .s_address(s_address), .s_read(s_read), .s_write(s_write),
    .s_writedata(s_writedata), .s_readdata(s_readdata), .s_waitrequest(s_waitrequest));
  rptlp_properties i_props (.clk_sys(clk_sys), .resetn(resetn),
    .address(i_rptlp_if.address), .read(i_rptlp_if.read), .write(i_rptlp_if.write),
    .writedata(i_rptlp_if.writedata), .readdata(i_rptlp_if.readdata),
    .waitrequest(i_rptlp_if.waitrequest), .irq(i_rptlp_if.irq));
  always #2 clk_sys = ~clk_sys;
  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic finish_test();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [65:0] got, input logic [65:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  // Holds the request until waitrequest is sampled low; idle edge after release
  task automatic sbus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    s_address <= a;
    s_write <= wr;
    s_read <= !wr;
    s_writedata <= d;
    do @(posedge clk_sys); while (s_waitrequest !== 1'b0);
    rd = s_readdata;
    s_read <= 1'b0;
    s_write <= 1'b0;
    @(posedge clk_sys);
  endtask : sbus
  task automatic wait_idle();
    do sbus(1'b0, rptlp_pkg::C_STATUS_OFS, 32'h0); while (rd !== 32'h0);
  endtask : wait_idle
  task automatic send(input logic [31:0] lo, input logic [31:0] hi, input logic s, input logic e);
    sbus(1'b1, rptlp_pkg::C_TX_LOW_OFS, lo);
    sbus(1'b1, rptlp_pkg::C_TX_HIGH_OFS, hi);
    exp_tx.push_back({s, e, hi, lo});
    pkt_open = !e;
    sbus(1'b1, rptlp_pkg::C_CMD_OFS, {28'h0, 1'b0, e, s, 1'b1});
    wait_idle();
  endtask : send
  task automatic push_cpl(input logic [65:0] d);
    cpl_data <= d;
    cpl_valid <= 1'b1;
    do @(posedge clk_sys); while (cpl_ready !== 1'b1);
    cpl_valid <= 1'b0;
    exp_rx.push_back(d);
    @(posedge clk_sys);
  endtask : push_cpl
  task automatic poll();
    logic [31:0] lo;
    logic [31:0] hi;
    sbus(1'b1, rptlp_pkg::C_CMD_OFS, 32'h8);
    wait_idle();
    sbus(1'b0, rptlp_pkg::C_RX_LOW_OFS, 32'h0);
    lo = rd;
    sbus(1'b0, rptlp_pkg::C_RX_HIGH_OFS, 32'h0);
    hi = rd;
    sbus(1'b0, rptlp_pkg::C_RX_FLAGS_OFS, 32'h0);
    check({rd[1:0], hi, lo}, exp_rx.pop_front(), "completion");
  endtask : poll
  // ****************************************************
  // Far side of the direct channel, with random stalls
  // ****************************************************
  always @(posedge clk_sys) begin
    tx_ready <= ($random(seed) & 3) != 0;
    cyc++;
    // Between qwords the priority follows the open-packet state alone
    if (resetn && exp_tx.size() == 0) begin
      check({65'h0, tx_reg_prio}, {65'h0, pkt_open}, "priority idle");
    end
    if (resetn && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      check({65'h0, tx_reg_prio}, 66'h1, "priority");
      check(tx_data, exp_tx.pop_front(), "tx qword");
    end
    if (cyc == 30000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    int n;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    // Each request kind as a three-qword packet, tags from 16 up
    foreach (kinds[i]) begin
      send({kinds[i], 24'(($random(seed)))}, {16'h0, 8'(16 + i), 8'h0f},
           1'b1, 1'b0);
      send($random(seed), $random(seed), 1'b0, 1'b0);
      send($random(seed), $random(seed), 1'b0, 1'b1);
    end
    send($random(seed), $random(seed), 1'b1, 1'b1);
    push_cpl({2'b11, 32'($random(seed)), 32'($random(seed))});
    push_cpl({2'b10, 32'($random(seed)), 32'($random(seed))});
    push_cpl({2'b01, 32'($random(seed)), 32'($random(seed))});
    n = 0;
    while (i_rptlp_if.irq !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    check({65'h0, i_rptlp_if.irq}, 66'h1, "irq");
    repeat (3) poll();
    sbus(1'b0, 8'h1c, 32'h0);
    check({34'h0, rd}, {34'h0, rptlp_pkg::UNMAPPED_WORD}, "unmapped");
    while (exp_tx.size() != 0) @(posedge clk_sys);
    finish_test();
  end
endmodule : tb_rptlp
